// ==== logic/cpu_memory_cycle_and_trap_control.sv ====
// Function
// - Load trap vectors from FFFC
// - Load trap waits for instruction end
// - Load trap ends idle state
// - Load at reset release follows reset
// - Reset holds write and bit strobes
// - Reset fetches vectors 0000/0002, clears status
// - Strobe low with address presented
// - Read direction high, write high
// - Fetch flag high on fetch
// - Ready in second cycle, sample next
// - Low ready inserts wait states
// - End read: strobes inactive, bus input
// - Write strobe low with data
// - Wait output on extended cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_cycle_and_trap_control (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RESET_N,
  input wire logic LOAD_N,
  input wire logic READY,
  input wire logic [15:0] DIN,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_FETCH,
  input wire logic [14:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic INSTR_END,
  input wire logic IDLE_REQ,
  input wire logic BIT_IO_REQ,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic MEM_CYCLE_STROBE_N,
  output logic READ_DIRECTION,
  output logic WE_N,
  output logic INSTR_FETCH_FLAG,
  output logic WAIT_OUT,
  output logic BIT_IO_STROBE,
  output logic [14:0] ADDR,
  output logic [15:0] DOUT,
  output logic DOUT_EN,
  output logic [15:0] WP_R,
  output logic [15:0] PC_R,
  output logic [15:0] STATUS_R,
  output logic RUNNING
);
  logic rst_m_r, rst_s_r, load_m_r, load_s_r, rdy_m_r, rdy_s_r;
  logic [15:0] din_m_r, din_s_r;
  logic load_pend_r, trap_sel_r, eng_start, eng_busy, eng_done;
  logic [14:0] eng_addr;
  logic [15:0] eng_rdata;
  logic bit_io_r;
  logic eng_rst, vec_pend_r;
  bus_cycle_pkg::seq_type sq_r;

  // Pins from outside pass two flops first
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= ~RESET_N;
      rst_s_r <= rst_m_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      load_m_r <= 1'b0;
      load_s_r <= 1'b0;
    end else begin
      load_m_r <= ~LOAD_N;
      load_s_r <= load_m_r;
    end
  end

  // Ready and data share one depth so data stays aligned to ready
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdy_m_r <= 1'b0;
      rdy_s_r <= 1'b0;
    end else begin
      rdy_m_r <= READY;
      rdy_s_r <= rdy_m_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      din_m_r <= 16'h0000;
      din_s_r <= 16'h0000;
    end else begin
      din_m_r <= DIN;
      din_s_r <= din_m_r;
    end
  end

  // Falling pin edge arms one trap; a held level never re-arms it
  logic load_d_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      load_d_r <= 1'b0;
    end else begin
      load_d_r <= load_s_r;
    end
  end

  // Pending load is sticky; a new edge wins over the trap's clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      load_pend_r <= 1'b0;
    end else if (load_s_r && !load_d_r) begin
      load_pend_r <= 1'b1;
    end else if (sq_r == bus_cycle_pkg::SQ_TRAP) begin
      load_pend_r <= 1'b0;
    end
  end

  always_comb begin
    if (sq_r == bus_cycle_pkg::SQ_VEC_WP) begin
      eng_addr = trap_sel_r ? bus_cycle_pkg::LOAD_WP_WADDR
                            : bus_cycle_pkg::RESET_WP_WADDR;
    end else if (sq_r == bus_cycle_pkg::SQ_VEC_PC) begin
      eng_addr = trap_sel_r ? bus_cycle_pkg::LOAD_PC_WADDR
                            : bus_cycle_pkg::RESET_PC_WADDR;
    end else begin
      eng_addr = REQ_ADDR;
    end
  end

  // Requests are refused outside run and while a cycle is open
  assign REQ_READY = (sq_r == bus_cycle_pkg::SQ_RUN) && !eng_busy
                     && !rst_s_r;
  // A finished vector read blocks a repeat start until the state moves
  assign eng_start = !rst_s_r && !eng_busy && !vec_pend_r &&
                     ((sq_r == bus_cycle_pkg::SQ_VEC_WP) ||
                      (sq_r == bus_cycle_pkg::SQ_VEC_PC) ||
                      (REQ_READY && REQ_VALID));
  assign RUNNING = (sq_r == bus_cycle_pkg::SQ_RUN);

  // Pin reset aborts an open cycle, so the write strobe rises
  assign eng_rst = SYS_RST || rst_s_r;

  mem_cycle_engine #(
    .AW(bus_cycle_pkg::ADDR_W),
    .DW(bus_cycle_pkg::DATA_W)
  ) u_engine (
    .clk(CLK),
    .rst(eng_rst),
    .start(eng_start),
    .is_write(RUNNING & REQ_WRITE),
    .is_fetch(RUNNING & REQ_FETCH),
    .addr(eng_addr),
    .wdata(REQ_WDATA),
    .ready_s(rdy_s_r),
    .din_s(din_s_r),
    .busy(eng_busy),
    .done(eng_done),
    .rdata_r(eng_rdata),
    .strobe_n_r(MEM_CYCLE_STROBE_N),
    .rd_dir_r(READ_DIRECTION),
    .we_n_r(WE_N),
    .fetch_r(INSTR_FETCH_FLAG),
    .wait_r(WAIT_OUT),
    .addr_r(ADDR),
    .dout_r(DOUT),
    .dout_en_r(DOUT_EN)
  );

  // Read data lands one cycle after done
  logic rsp_pend_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rsp_pend_r <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 16'h0000;
    end else begin
      rsp_pend_r <= eng_done && (sq_r == bus_cycle_pkg::SQ_RUN);
      RSP_VALID <= rsp_pend_r;
      if (rsp_pend_r) begin
        RSP_RDATA <= eng_rdata;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      vec_pend_r <= 1'b0;
    end else begin
      vec_pend_r <= eng_done && ((sq_r == bus_cycle_pkg::SQ_VEC_WP) ||
                                 (sq_r == bus_cycle_pkg::SQ_VEC_PC));
    end
  end

  // Vectors land one cycle after the engine reports done
  logic wp_take, pc_take;
  assign wp_take = vec_pend_r && (sq_r == bus_cycle_pkg::SQ_VEC_WP);
  assign pc_take = vec_pend_r && (sq_r == bus_cycle_pkg::SQ_VEC_PC);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sq_r <= bus_cycle_pkg::SQ_RESET;
    end else if (rst_s_r) begin
      sq_r <= bus_cycle_pkg::SQ_RESET;
    end else begin
      case (sq_r)
        bus_cycle_pkg::SQ_RESET: begin
          if (!eng_busy) begin
            sq_r <= bus_cycle_pkg::SQ_VEC_WP;
          end
        end
        bus_cycle_pkg::SQ_VEC_WP: begin
          if (wp_take) begin
            sq_r <= bus_cycle_pkg::SQ_VEC_PC;
          end
        end
        bus_cycle_pkg::SQ_VEC_PC: begin
          // Load honoured only after vector pair
          if (pc_take) begin
            sq_r <= bus_cycle_pkg::SQ_RUN;
          end
        end
        bus_cycle_pkg::SQ_RUN: begin
          if (load_pend_r && INSTR_END && !eng_busy && !REQ_VALID) begin
            sq_r <= bus_cycle_pkg::SQ_TRAP;
          // Idle entry also waits for an instruction end
          end else if (IDLE_REQ && INSTR_END && !eng_busy) begin
            sq_r <= bus_cycle_pkg::SQ_IDLE;
          end
        end
        bus_cycle_pkg::SQ_IDLE: begin
          if (load_pend_r) begin
            sq_r <= bus_cycle_pkg::SQ_TRAP;
          end
        end
        bus_cycle_pkg::SQ_TRAP: begin
          // Vector pair is read next
          sq_r <= bus_cycle_pkg::SQ_VEC_WP;
        end
        default: begin
          sq_r <= bus_cycle_pkg::SQ_RESET;
        end
      endcase
    end
  end

  // Trap selects the top vector pair
  always_ff @(posedge CLK) begin
    if (SYS_RST || rst_s_r) begin
      trap_sel_r <= 1'b0;
    end else if (sq_r == bus_cycle_pkg::SQ_RESET) begin
      trap_sel_r <= 1'b0;
    end else if (sq_r == bus_cycle_pkg::SQ_TRAP) begin
      trap_sel_r <= 1'b1;
    end
  end

  // Workspace pointer comes only from vector reads
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WP_R <= 16'h0000;
    end else if (wp_take) begin
      WP_R <= eng_rdata;
    end
  end

  // Program counter loads after the workspace word
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PC_R <= 16'h0000;
    end else if (pc_take) begin
      PC_R <= eng_rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STATUS_R <= bus_cycle_pkg::ST_RESET_VAL;
    end else if (sq_r == bus_cycle_pkg::SQ_RESET) begin
      STATUS_R <= bus_cycle_pkg::ST_RESET_VAL;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bit_io_r <= 1'b0;
    end else begin
      bit_io_r <= BIT_IO_REQ && RUNNING && !rst_s_r;
    end
  end
  assign BIT_IO_STROBE = bit_io_r;
endmodule
`default_nettype wire

// ==== logic/bus_cycle_pkg.sv ====
package bus_cycle_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  // Word addresses of the vector pairs (byte addresses shifted right)
  localparam logic [14:0] RESET_WP_WADDR = 15'h0000;
  localparam logic [14:0] RESET_PC_WADDR = 15'h0001;
  localparam logic [14:0] LOAD_WP_WADDR = 15'h7FFE;
  localparam logic [14:0] LOAD_PC_WADDR = 15'h7FFF;
  localparam logic [15:0] ST_RESET_VAL = 16'h0000;
  localparam int RESET_MIN_CYCLES = 3;
  // Edges a ready sample needs to cross the pin synchroniser
  localparam logic [1:0] READY_LAG = 2'h2;
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_ADDR = 4'h2,
    PH_WAIT = 4'h4,
    PH_DONE = 4'h8
  } phase_type;
  typedef enum logic [5:0] {
    SQ_RESET = 6'h01,
    SQ_VEC_WP = 6'h02,
    SQ_VEC_PC = 6'h04,
    SQ_RUN = 6'h08,
    SQ_IDLE = 6'h10,
    SQ_TRAP = 6'h20
  } seq_type;
endpackage

// ==== logic/mem_cycle_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_cycle_engine #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic is_fetch,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic ready_s,
  input wire logic [DW-1:0] din_s,
  output logic busy,
  output logic done,
  output logic [DW-1:0] rdata_r,
  output logic strobe_n_r,
  output logic rd_dir_r,
  output logic we_n_r,
  output logic fetch_r,
  output logic wait_r,
  output logic [AW-1:0] addr_r,
  output logic [DW-1:0] dout_r,
  output logic dout_en_r
);
  bus_cycle_pkg::phase_type ph_r;
  logic [1:0] lag_r;
  initial begin
    if (AW < 1 || DW < 1) $error("bad width");
  end
  assign busy = (ph_r != bus_cycle_pkg::PH_IDLE);
  assign done = (ph_r == bus_cycle_pkg::PH_DONE);
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_r <= bus_cycle_pkg::PH_IDLE;
      strobe_n_r <= 1'b1;
      rd_dir_r <= 1'b0;
      we_n_r <= 1'b1;
      fetch_r <= 1'b0;
      wait_r <= 1'b0;
      addr_r <= '0;
      dout_r <= '0;
      dout_en_r <= 1'b0;
      rdata_r <= '0;
      lag_r <= 2'h0;
    end else begin
      case (ph_r)
        bus_cycle_pkg::PH_IDLE: begin
          if (start) begin
            strobe_n_r <= 1'b0;
            addr_r <= addr;
            rd_dir_r <= ~is_write;
            fetch_r <= is_fetch & ~is_write;
            we_n_r <= ~is_write;
            dout_r <= wdata;
            dout_en_r <= is_write;
            ph_r <= bus_cycle_pkg::PH_ADDR;
            lag_r <= bus_cycle_pkg::READY_LAG;
          end
        end
        bus_cycle_pkg::PH_ADDR, bus_cycle_pkg::PH_WAIT: begin
          // Ready in second cycle
          // Synchronised ready trails the pin; judge it only once it
          // reflects a cycle in which the strobe was already low
          if (lag_r != 2'h0) begin
            lag_r <= lag_r - 2'h1;
          end else if (ready_s) begin
            wait_r <= 1'b0;
            ph_r <= bus_cycle_pkg::PH_DONE;
          end else begin
            wait_r <= 1'b1;
            ph_r <= bus_cycle_pkg::PH_WAIT;
          end
        end
        bus_cycle_pkg::PH_DONE: begin
          // Data sampled the cycle after ready
          rdata_r <= din_s;
          strobe_n_r <= 1'b1;
          rd_dir_r <= 1'b0;
          we_n_r <= 1'b1;
          fetch_r <= 1'b0;
          dout_en_r <= 1'b0;
          ph_r <= bus_cycle_pkg::PH_IDLE;
        end
        default: ph_r <= bus_cycle_pkg::PH_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bench/mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic strobe_n,
  input wire logic [14:0] addr,
  input wire logic [3:0] slow,
  output logic ready,
  output logic [15:0] din
);
  logic [3:0] cnt_r = 4'h0;
  logic [15:0] last_r = 16'h0000;
  assign ready = !strobe_n && (cnt_r >= slow);
  // Released bus shows the inverse of the previous cycle's value, so stale data can match every other cycle
  assign din = strobe_n ? ~last_r : ~{1'b0, addr};
  always @(posedge clk) begin
    cnt_r <= strobe_n ? 4'h0 : cnt_r + 4'h1;
    last_r <= din;
  end
endmodule
`default_nettype wire

// ==== bench/cpu_trap_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_asserts (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RESET_N,
  input wire logic READY,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic REQ_FETCH,
  input wire logic [14:0] REQ_ADDR,
  input wire logic MEM_CYCLE_STROBE_N,
  input wire logic READ_DIRECTION,
  input wire logic WE_N,
  input wire logic INSTR_FETCH_FLAG,
  input wire logic WAIT_OUT,
  input wire logic BIT_IO_STROBE,
  input wire logic [14:0] ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire take = REQ_VALID && REQ_READY;
  sequence fall_s;
    $fell(MEM_CYCLE_STROBE_N);
  endsequence
  sequence stall_s;
    fall_s ##0 (!READY) [*4];
  endsequence
  sequence quick_s;
    fall_s ##0 READY [*3];
  endsequence
  idle_bus_a: assert property (
    MEM_CYCLE_STROBE_N |-> WE_N && !READ_DIRECTION && !INSTR_FETCH_FLAG)
    else $error("bus active when idle");
  dir_write_a: assert property (
    !MEM_CYCLE_STROBE_N |-> READ_DIRECTION == WE_N)
    else $error("direction and write clash");
  take_addr_a: assert property (
    take |=> !MEM_CYCLE_STROBE_N && ADDR == $past(REQ_ADDR))
    else $error("no cycle after take");
  fetch_flag_a: assert property (
    take && REQ_FETCH && !REQ_WRITE |=> INSTR_FETCH_FLAG)
    else $error("fetch flag missing");
  write_low_a: assert property (
    take && REQ_WRITE |=> !WE_N)
    else $error("write strobe missing");
  reset_quiet_a: assert property (
    (!RESET_N) [*8] |-> WE_N && !BIT_IO_STROBE)
    else $error("strobe active in reset");
  stall_wait_a: assert property (
    stall_s |-> ##[0:3] WAIT_OUT)
    else $error("wait output missing");
  quick_end_a: assert property (
    quick_s |-> ##[0:5] $rose(MEM_CYCLE_STROBE_N))
    else $error("ready cycle not ended");
endmodule
bind cpu_memory_cycle_and_trap_control cpu_trap_asserts u_asserts (
  .CLK, .SYS_RST, .RESET_N, .READY, .REQ_VALID, .REQ_READY, .REQ_WRITE,
  .REQ_FETCH, .REQ_ADDR, .MEM_CYCLE_STROBE_N, .READ_DIRECTION, .WE_N,
  .INSTR_FETCH_FLAG, .WAIT_OUT, .BIT_IO_STROBE, .ADDR
);
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLK = 1'b0, SYS_RST = 1'b1, RESET_N = 1'b0, LOAD_N = 1'b1;
  logic REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_FETCH = 1'b0;
  logic INSTR_END = 1'b0, IDLE_REQ = 1'b0, BIT_IO_REQ = 1'b0;
  logic [14:0] REQ_ADDR = 15'h0000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic [3:0] slow = 4'h0;
  logic READY, REQ_READY, RSP_VALID, MEM_CYCLE_STROBE_N, READ_DIRECTION;
  logic WE_N, INSTR_FETCH_FLAG, WAIT_OUT, BIT_IO_STROBE, DOUT_EN, RUNNING;
  logic [14:0] ADDR;
  logic [15:0] DIN, RSP_RDATA, DOUT, WP_R, PC_R, STATUS_R;
  int err_total = 0, checks = 0, cyc = 0;
  cpu_memory_cycle_and_trap_control u_cpu_memory_cycle_and_trap_control (
    .CLK, .SYS_RST, .RESET_N, .LOAD_N, .READY, .DIN, .REQ_VALID,
    .REQ_WRITE, .REQ_FETCH, .REQ_ADDR, .REQ_WDATA, .INSTR_END, .IDLE_REQ,
    .BIT_IO_REQ, .REQ_READY, .RSP_VALID, .RSP_RDATA, .MEM_CYCLE_STROBE_N,
    .READ_DIRECTION, .WE_N, .INSTR_FETCH_FLAG, .WAIT_OUT, .BIT_IO_STROBE,
    .ADDR, .DOUT, .DOUT_EN, .WP_R, .PC_R, .STATUS_R, .RUNNING
  );
  mem_model u_mem_model (
    .clk(CLK), .strobe_n(MEM_CYCLE_STROBE_N), .addr(ADDR), .slow(slow),
    .ready(READY), .din(DIN)
  );
  initial forever #10 CLK = ~CLK;
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wait_run;
    int i;
    i = 0;
    while (RUNNING !== 1'b1 && i < 300) begin
      @(posedge CLK);
      i++;
    end
    chk("running", 16'(RUNNING), 16'h0001);
    tick(1);
  endtask
  task automatic req(input logic wr, input logic [14:0] a);
    int i;
    i = 0;
    REQ_WRITE <= wr;
    REQ_FETCH <= a[0];
    REQ_ADDR <= a;
    REQ_WDATA <= 16'hC3A5;
    REQ_VALID <= 1'b1;
    do begin
      @(posedge CLK);
      i++;
    end while (REQ_READY !== 1'b1 && i < 50);
    REQ_VALID <= 1'b0;
    tick(1);
  endtask
  task automatic t_read(input logic [14:0] a, input logic [3:0] s);
    int i;
    logic w;
    slow <= s;
    req(1'b0, a);
    chk("dir", 16'(READ_DIRECTION), 16'h0001);
    chk("fetch", 16'(INSTR_FETCH_FLAG), 16'(a[0]));
    w = WAIT_OUT;
    i = 0;
    while (RSP_VALID !== 1'b1 && i < 60) begin
      @(posedge CLK);
      w = w | WAIT_OUT;
      i++;
    end
    chk("rdata", RSP_RDATA, ~{1'b0, a});
    chk("wait", 16'(w), 16'(s != 4'h0));
    chk("dir end", 16'(READ_DIRECTION), 16'h0000);
    $display("read %h done", a);
  endtask
  task automatic t_write;
    req(1'b1, 15'h1234);
    chk("dout", DOUT, 16'hC3A5);
    chk("dout_en", 16'(DOUT_EN), 16'h0001);
    chk("we_n low", 16'(WE_N), 16'h0000);
    tick(14);
    chk("we_n", 16'(WE_N), 16'h0001);
    $display("write done");
  endtask
  task automatic t_load;
    LOAD_N <= 1'b0;
    tick(8);
    chk("pc hold", PC_R, 16'hFFFE);
    INSTR_END <= 1'b1;
    tick(3);
    LOAD_N <= 1'b1;
    wait_run;
    chk("load wp", WP_R, 16'h8001);
    chk("load pc", PC_R, 16'h8000);
    $display("load done");
  endtask
  task automatic t_idle(input logic ld);
    IDLE_REQ <= 1'b1;
    tick(4);
    IDLE_REQ <= 1'b0;
    tick(4);
    chk("idle", 16'(RUNNING), 16'h0000);
    LOAD_N <= ~ld;
    // with ld low reset is held well over three cycles; with ld high LOAD_N is held low instead
    RESET_N <= ld;
    BIT_IO_REQ <= 1'b1;
    tick(10);
    chk("bit rst", 16'(BIT_IO_STROBE), 16'h0000);
    LOAD_N <= 1'b1;
    RESET_N <= 1'b1;
    BIT_IO_REQ <= 1'b0;
    tick(3);
    wait_run;
    chk("idle exit", PC_R, ld ? 16'h8000 : 16'hFFFE);
    BIT_IO_REQ <= 1'b1;
    tick(2);
    chk("bit run", 16'(BIT_IO_STROBE), 16'h0001);
    BIT_IO_REQ <= 1'b0;
    $display("idle exit done");
  endtask
  task automatic t_load_reset;
    INSTR_END <= 1'b0;
    RESET_N <= 1'b0;
    LOAD_N <= 1'b0;
    tick(6);
    RESET_N <= 1'b1;
    tick(30);
    LOAD_N <= 1'b1;
    wait_run;
    chk("reset first", PC_R, 16'hFFFE);
    INSTR_END <= 1'b1;
    tick(3);
    wait_run;
    chk("order pc", PC_R, 16'h8000);
    $display("load at reset done");
  endtask
  initial begin
    tick(10);
    SYS_RST <= 1'b0;
    RESET_N <= 1'b1;
    wait_run;
    chk("wp", WP_R, 16'hFFFF);
    chk("pc", PC_R, 16'hFFFE);
    chk("st", STATUS_R, 16'h0000);
    t_read(15'h0100, 4'h0);
    t_read(15'h0101, 4'h2);
    t_read(15'h7FFF, 4'h4);
    t_write;
    t_load;
    t_idle(1'b0);
    t_idle(1'b1);
    t_load_reset;
    final_report;
  end
endmodule
`default_nettype wire
